// *** hw/sfr_map.sv ***
// special-function register window of the core
`timescale 1ns/100ps
`default_nettype none
`include "sfr_map_consts.svh"
module sfr_map
    import sfr_types_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire sfr_req_s req_in,
    input wire bit_req_s bit_in,
    input wire core_evt_s evt_in,
    input wire ser_byte_s [1:0] rx_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic bit_data_out,
    output logic bit_valid_out,
    output logic [15:0] ptr_addr_out,
    output logic [7:0] stack_out,
    output logic [3:0][7:0] port_out,
    output ser_byte_s [1:0] tx_out,
    output logic [1:0][7:0] ser_ctl_out,
    output logic [7:0] psel_out
);
    // reset value, writable bits and protected bits of each plain location
    function automatic reg_info_s info(input logic [7:0] a);
        reg_info_s r;
        r = '{`R_ZERO, `M_NONE, `M_NONE};
        case (a) // [RQ3]
            `A_PORT0: r = '{`R_PORT, `M_FULL, `M_NONE}; // [RQ10]
            `A_PORT1: r = '{`R_PORT, `M_FULL, `M_NONE}; // [RQ10]
            `A_PORT2: r = '{`R_PORT, `M_FULL, `M_NONE}; // [RQ10]
            `A_PORT3: r = '{`R_PORT, `M_FULL, `M_NONE}; // [RQ10]
            `A_PWRCTL: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_TMRCTL: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_TMRMODE: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_TMR0L: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ11]
            `A_TMR1L: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ11]
            `A_TMR0H: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ11]
            `A_TMR1H: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ11]
            `A_TMR2L: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ11]
            `A_TMR2H: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ11]
            `A_CLKCTL: r = '{`R_CLKCTL, `M_FULL, `M_NONE};
            `A_EXTIRQ: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_TCLKHI: r = '{`R_TCLKHI, `M_TCLKHI, `M_NONE};
            `A_SER0CTL: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ13]
            `A_SER1CTL: r = '{`R_ZERO, `M_FULL, `M_NONE}; // [RQ13]
            `A_PAGECTL: r = '{`R_PAGECTL, `M_PAGECTL, `P_PAGECTL};
            `A_IRQEN: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_SER0ADR: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_SER1ADR: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_SER0MSK: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_SER1MSK: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_PRIHI: r = '{`R_PRI, `M_PRI, `M_NONE};
            `A_PRILO: r = '{`R_PRI, `M_PRI, `M_NONE};
            `A_ROMSZ: r = '{`R_ROMSZ, `M_ROMSZ, `P_ROMSZ};
            `A_PWRMODE: r = '{`R_PWRMODE, `M_FULL, `M_NONE};
            `A_PRISTAT: r = '{`R_PRISTAT, `M_NONE, `M_NONE};
            `A_TMR2CTL: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_TMR2MODE: r = '{`R_TMR2MODE, `M_TMR2MODE, `M_NONE};
            `A_TMR2RLL: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_TMR2RLH: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_PSWORD: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_FLCMD: r = '{`R_FLCMD, `M_FLCMD, `M_NONE};
            `A_FLDATA: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_WDCTL: r = '{`R_ZERO, `M_FULL, `P_WDCTL};
            `A_OPND: r = '{`R_ZERO, `M_FULL, `M_NONE};
            `A_EIRQEN: r = '{`R_EIRQEN, `M_EIRQEN, `M_NONE};
            `A_AUXOP: r = '{`R_ZERO, `M_FULL, `M_NONE};
            default: r = '{`R_ZERO, `M_NONE, `M_NONE}; // [RQ17]
        endcase
        return r;
    endfunction : info

    logic [7:0] gen_q [0:127];
    logic [7:0] ram_r [0:127];
    logic [1:0][15:0] dp_r;
    logic [1:0][15:0] dp_nxt;
    logic [7:0] psel_r;
    logic [7:0] psel_nxt;
    logic [7:0] sp_r;
    logic [1:0][7:0] rxbuf_r;
    logic byte_hit;
    logic ind_hit;
    logic bit_hit;
    logic [6:0] look_a;
    logic [7:0] look8;
    logic [7:0] cur;
    logic wr_en;
    logic [7:0] wr_d;
    logic [7:0] onehot;
    logic key_open;
    logic [7:0] key_val;
    logic ptr_use;
    logic sel;

    // only the top half answers: direct addressing reaches the registers, indirect the scratchpad
    assign byte_hit = req_in.addr[7] && !req_in.ind && (req_in.rd || req_in.wr); // [RQ1]
    assign ind_hit = req_in.addr[7] && req_in.ind && (req_in.rd || req_in.wr); // [RQ15]
    // byte access wins; a bit op in the same cycle is dropped
    assign bit_hit = bit_in.valid && bit_in.addr[7] && !(req_in.rd || req_in.wr); // [RQ2]
    assign look_a = byte_hit ? req_in.addr[6:0] : {bit_in.addr[6:3], 3'h0}; // [RQ2]
    assign look8 = {1'b1, look_a};
    assign onehot = 8'h01 << bit_in.addr[2:0];
    assign wr_en = (byte_hit && req_in.wr) || (bit_hit && bit_in.op != BIT_READ); // [RQ14]

    always_comb begin
        unique case (bit_in.op)
            BIT_SET: wr_d = cur | onehot; // [RQ2]
            BIT_CLEAR: wr_d = cur & ~onehot; // [RQ2]
            BIT_WRITE: wr_d = bit_in.val ? (cur | onehot) : (cur & ~onehot);
            BIT_READ: wr_d = cur;
        endcase
        if (byte_hit) begin
            wr_d = req_in.data;
        end
    end

    // one read mux serves byte reads and the read half of bit ops
    always_comb begin
        case (look8)
            `A_PTR0L: cur = dp_r[0][7:0]; // [RQ4]
            `A_PTR0H: cur = dp_r[0][15:8]; // [RQ4]
            `A_PTR1L: cur = dp_r[1][7:0]; // [RQ4]
            `A_PTR1H: cur = dp_r[1][15:8]; // [RQ4]
            `A_PSEL: cur = psel_r;
            `A_STACK: cur = sp_r;
            `A_SER0BUF: cur = rxbuf_r[0]; // [RQ12]
            `A_SER1BUF: cur = rxbuf_r[1]; // [RQ12]
            `A_KEY: cur = key_val;
            default: cur = gen_q[look_a];
        endcase
    end

    // plain locations; reserved bits hold their reset value forever
    for (genvar i = 0; i < 128; i++) begin : g_reg
        localparam reg_info_s INF = info(8'(i + 128));
        if (INF.wmask == `M_NONE) begin : g_fix
            assign gen_q[i] = INF.rst; // [RQ17]
        end else begin : g_ff
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    gen_q[i] <= INF.rst;
                end else if (wr_en && look_a == 7'(i)) begin
                    gen_q[i] <= (gen_q[i] & ~(INF.wmask & ~(key_open ? `M_NONE : INF.pmask)))
                        | (wr_d & INF.wmask & ~(key_open ? `M_NONE : INF.pmask)); // [RQ16]
                end
            end
        end
    end

    key_unlock u_key (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_in(wr_en && look8 == `A_KEY),
        .data_in(wr_d),
        .open_out(key_open),
        .key_out(key_val)
    );

    // upper scratchpad, reached only by indirect addressing; no reset, like any ram
    always_ff @(posedge clk_in) begin
        if (ind_hit && req_in.wr) begin
            ram_r[req_in.addr[6:0]] <= req_in.data; // [RQ15]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= (byte_hit || ind_hit) && req_in.rd; // [RQ1]
            rd_data_out <= ind_hit ? ram_r[req_in.addr[6:0]] : cur; // [RQ15]
        end
    end

    // bit ops answer with the bit as it stood before the op
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_data_out <= 1'b0;
            bit_valid_out <= 1'b0;
        end else begin
            bit_valid_out <= bit_hit; // [RQ2]
            bit_data_out <= cur[bit_in.addr[2:0]];
        end
    end

    // pointers: a write to a pointer or select register in the same cycle as a pointer use wins
    assign ptr_use = evt_in.external_data_move || evt_in.inc;
    assign sel = psel_r[`SEL_BIT];
    always_comb begin
        dp_nxt = dp_r;
        psel_nxt = psel_r;
        if (wr_en && look8 == `A_PTR0L) begin
            dp_nxt[0][7:0] = wr_d; // [RQ4]
        end else if (wr_en && look8 == `A_PTR0H) begin
            dp_nxt[0][15:8] = wr_d;
        end else if (wr_en && look8 == `A_PTR1L) begin
            dp_nxt[1][7:0] = wr_d;
        end else if (wr_en && look8 == `A_PTR1H) begin
            dp_nxt[1][15:8] = wr_d;
        end else if (wr_en && look8 == `A_PSEL) begin
            psel_nxt = (psel_r & ~`M_PSEL) | (wr_d & `M_PSEL); // [RQ5]
        end else if (ptr_use) begin
            if (evt_in.inc) begin
                dp_nxt[sel] = dp_r[sel] + 16'h0001;
            end else if (psel_r[`STEP_EN_BIT]) begin
                dp_nxt[sel] = psel_r[`DIR0_BIT + 32'(sel)] ? dp_r[sel] - 16'h0001
                    : dp_r[sel] + 16'h0001; // [RQ7]
            end
            if (psel_r[`TOGGLE_EN_BIT]) begin
                psel_nxt[`SEL_BIT] = ~sel; // [RQ6]
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dp_r <= '0;
            psel_r <= `R_PSEL;
            ptr_addr_out <= 16'h0000;
        end else begin
            dp_r <= dp_nxt;
            psel_r <= psel_nxt;
            // registered copy of the active pointer keeps the output glitch free
            ptr_addr_out <= psel_nxt[`SEL_BIT] ? dp_nxt[1] : dp_nxt[0]; // [RQ4] [RQ5]
        end
    end

    // stack pointer points at the last used entry: push pre-increments
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sp_r <= `R_STACK;
        end else if (wr_en && look8 == `A_STACK) begin
            sp_r <= wr_d; // [RQ9]
        end else if (evt_in.push) begin
            sp_r <= sp_r + 8'h01; // [RQ8]
        end else if (evt_in.pop) begin
            sp_r <= sp_r - 8'h01; // [RQ8]
        end
    end

    // serial buffers: writes go to the transmitter, reads come from the receiver
    for (genvar k = 0; k < 2; k++) begin : g_ser
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                rxbuf_r[k] <= 8'h00;
                tx_out[k] <= '0;
            end else begin
                if (rx_in[k].load) begin
                    rxbuf_r[k] <= rx_in[k].data; // [RQ12]
                end
                tx_out[k].load <= wr_en && look8 == (k == 0 ? `A_SER0BUF : `A_SER1BUF); // [RQ12]
                if (wr_en && look8 == (k == 0 ? `A_SER0BUF : `A_SER1BUF)) begin
                    tx_out[k].data <= wr_d;
                end
            end
        end
    end

    assign port_out[0] = gen_q[7'(`A_PORT0)]; // [RQ10]
    assign port_out[1] = gen_q[7'(`A_PORT1)];
    assign port_out[2] = gen_q[7'(`A_PORT2)];
    assign port_out[3] = gen_q[7'(`A_PORT3)];
    assign ser_ctl_out[0] = gen_q[7'(`A_SER0CTL)]; // [RQ13]
    assign ser_ctl_out[1] = gen_q[7'(`A_SER1CTL)]; // [RQ13]
    assign stack_out = sp_r;
    assign psel_out = psel_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_ind_misses_port;
        req_in.ind && req_in.wr && req_in.addr == `A_PORT0 |=> $stable(port_out[0]);
    endproperty
    a_ind_misses_port: assert property (p_ind_misses_port) else $error("indirect write hit port latch"); // [RQ15]

    property p_low_half_silent;
        req_in.rd && !req_in.addr[7] |=> !rd_valid_out;
    endproperty
    a_low_half_silent: assert property (p_low_half_silent) else $error("answered below window"); // [RQ1]

    property p_ptr_active;
        ptr_addr_out == (psel_r[`SEL_BIT] ? dp_r[1] : dp_r[0]);
    endproperty
    a_ptr_active: assert property (p_ptr_active) else $error("pointer output not active pointer"); // [RQ5]

    property p_toggle;
        ptr_use && !wr_en && psel_r[`TOGGLE_EN_BIT] |=> psel_r[`SEL_BIT] != $past(sel);
    endproperty
    a_toggle: assert property (p_toggle) else $error("pointer select did not flip"); // [RQ6]

    property p_step_up;
        evt_in.external_data_move && !evt_in.inc && !wr_en && psel_r[`STEP_EN_BIT] && !sel
            && !psel_r[`DIR0_BIT] |=> dp_r[0] == $past(dp_r[0]) + 16'h0001;
    endproperty
    a_step_up: assert property (p_step_up) else $error("pointer did not step up"); // [RQ7]

    property p_push;
        evt_in.push && !(wr_en && look8 == `A_STACK) |=> stack_out == $past(sp_r) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push did not advance stack"); // [RQ8]

    property p_stack_write;
        byte_hit && req_in.wr && req_in.addr == `A_STACK ##1 !evt_in.push && !evt_in.pop
            |=> stack_out == $past(req_in.data, 2);
    endproperty
    a_stack_write: assert property (p_stack_write) else $error("stack write lost"); // [RQ9]

    property p_locked;
        wr_en && look8 == `A_WDCTL && !key_open
            |=> (gen_q[7'(`A_WDCTL)] & `P_WDCTL) == ($past(gen_q[7'(`A_WDCTL)]) & `P_WDCTL);
    endproperty
    a_locked: assert property (p_locked) else $error("protected bit changed while locked"); // [RQ16]

    property p_buffer_split;
        byte_hit && req_in.wr && req_in.addr == `A_SER0BUF
            |=> tx_out[0].load && tx_out[0].data == $past(req_in.data) && $stable(rxbuf_r[0]);
    endproperty
    a_buffer_split: assert property (p_buffer_split) else $error("serial buffer write misrouted"); // [RQ12]

    property p_bit_set;
        bit_hit && bit_in.op == BIT_SET && bit_in.addr[7:3] == 5'h12
            |=> port_out[1][$past(bit_in.addr[2:0])];
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set did not reach latch"); // [RQ2]

    property p_undef_zero;
        byte_hit && req_in.rd && req_in.addr == 8'h8f |=> rd_valid_out && rd_data_out == 8'h00;
    endproperty
    a_undef_zero: assert property (p_undef_zero) else $error("undefined location not zero"); // [RQ17]

    c_toggle: cover property (ptr_use && psel_r[`TOGGLE_EN_BIT] ##1 ptr_use);
    c_unlocked: cover property (wr_en && look8 == `A_WDCTL && key_open);
    c_bit_clear: cover property (bit_hit && bit_in.op == BIT_CLEAR);
    c_ind_read: cover property (ind_hit && req_in.rd);
endmodule : sfr_map
`default_nettype wire

// *** hw/sfr_map_consts.svh ***
// register window constants: offsets, reset values, field masks and timing counts
// Summary of operation
// RQ1 - direct accesses to 80h-FFh reach the register window; indirect ones never do
// RQ2 - registers at addresses ending 0h or 8h allow single-bit read, set, clear, test
// RQ3 - every baseline location keeps its address; added functions use only spare ones
// RQ4 - two 16-bit pointers, byte-wide halves, active one addresses external data moves
// RQ5 - select bit 0 chooses which pointer is active
// RQ6 - with select bit 5 set, active pointer flips after each pointer use; no flip when a pointer or select register write falls in the same cycle
// RQ7 - when enabled, active pointer steps up or down after use, per direction bit; no step when a pointer or select register write falls in the same cycle
// RQ8 - stack pointer always holds the location of the last pushed entry
// RQ9 - stack pointer takes any written value, anywhere in the 256-byte scratchpad
// RQ10 - four 8-bit port latches, one location each, keep the last written value
// RQ11 - each of three 16-bit timers shows as separate readable, writable low/high bytes
// RQ12 - each serial buffer address reads one store and writes another
// RQ13 - each serial port has its own control register
// RQ14 - all peripheral control and status goes only through register accesses
// RQ15 - indirect accesses to 80h-FFh reach the upper 128 scratchpad bytes
// RQ16 - protected control bits change only inside the timed-access unlock window
// RQ17 - undefined locations and reserved bits read fixed values; writes do nothing
`ifndef SFR_MAP_CONSTS_SVH
`define SFR_MAP_CONSTS_SVH
`define A_PORT0 8'h80
`define A_STACK 8'h81
`define A_PTR0L 8'h82
`define A_PTR0H 8'h83
`define A_PTR1L 8'h84
`define A_PTR1H 8'h85
`define A_PSEL 8'h86
`define A_PWRCTL 8'h87
`define A_TMRCTL 8'h88
`define A_TMRMODE 8'h89
`define A_TMR0L 8'h8a
`define A_TMR1L 8'h8b
`define A_TMR0H 8'h8c
`define A_TMR1H 8'h8d
`define A_CLKCTL 8'h8e
`define A_PORT1 8'h90
`define A_EXTIRQ 8'h91
`define A_TCLKHI 8'h96
`define A_SER0CTL 8'h98
`define A_SER0BUF 8'h99
`define A_PAGECTL 8'h9d
`define A_PORT2 8'ha0
`define A_IRQEN 8'ha8
`define A_SER0ADR 8'ha9
`define A_SER1ADR 8'haa
`define A_PORT3 8'hb0
`define A_PRIHI 8'hb1
`define A_PRILO 8'hb8
`define A_SER0MSK 8'hb9
`define A_SER1MSK 8'hba
`define A_SER1CTL 8'hc0
`define A_SER1BUF 8'hc1
`define A_ROMSZ 8'hc2
`define A_PWRMODE 8'hc4
`define A_PRISTAT 8'hc5
`define A_KEY 8'hc7
`define A_TMR2CTL 8'hc8
`define A_TMR2MODE 8'hc9
`define A_TMR2RLL 8'hca
`define A_TMR2RLH 8'hcb
`define A_TMR2L 8'hcc
`define A_TMR2H 8'hcd
`define A_PSWORD 8'hd0
`define A_FLCMD 8'hd5
`define A_FLDATA 8'hd6
`define A_WDCTL 8'hd8
`define A_OPND 8'he0
`define A_EIRQEN 8'he8
`define A_AUXOP 8'hf0
`define R_ZERO 8'h00
`define R_PORT 8'hff
`define R_STACK 8'h07
`define R_PSEL 8'h04
`define R_CLKCTL 8'h01
`define R_TCLKHI 8'hc7
`define R_PAGECTL 8'h1f
`define R_PRI 8'h80
`define R_ROMSZ 8'hf5
`define R_PWRMODE 8'h80
`define R_PRISTAT 8'h10
`define R_KEY 8'hff
`define R_TMR2MODE 8'hfc
`define R_FLCMD 8'hb0
`define R_EIRQEN 8'he0
`define M_FULL 8'hff
`define M_NONE 8'h00
`define M_PSEL 8'hf1
`define M_TCLKHI 8'h38
`define M_PAGECTL 8'he0
`define M_PRI 8'h7f
`define M_ROMSZ 8'h0f
`define M_TMR2MODE 8'h03
`define M_FLCMD 8'h0f
`define M_EIRQEN 8'h1f
`define P_PAGECTL 8'he0
`define P_ROMSZ 8'h0f
`define P_WDCTL 8'h0b
`define SEL_BIT 0
`define STEP_EN_BIT 4
`define TOGGLE_EN_BIT 5
`define DIR0_BIT 6
`define KEY_FIRST 8'haa
`define KEY_SECOND 8'h55
`define KEY_WIN_CYC 3'h4
`endif

// *** hw/sfr_types_pkg.sv ***
// types shared by the register window and its unlock sequencer
package sfr_types_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic ind;
        logic [7:0] addr;
        logic [7:0] data;
    } sfr_req_s;
    typedef enum logic [1:0] {BIT_READ, BIT_SET, BIT_CLEAR, BIT_WRITE} bit_op_e;
    typedef struct packed {
        logic valid;
        bit_op_e op;
        logic [7:0] addr;
        logic val;
    } bit_req_s;
    typedef struct packed {
        logic push;
        logic pop;
        logic external_data_move;
        logic inc;
    } core_evt_s;
    typedef struct packed {
        logic load;
        logic [7:0] data;
    } ser_byte_s;
    typedef struct packed {
        logic [7:0] rst;
        logic [7:0] wmask;
        logic [7:0] pmask;
    } reg_info_s;
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_e;
endpackage : sfr_types_pkg

// *** hw/key_unlock.sv ***
// timed-access unlock sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sfr_map_consts.svh"
module key_unlock
    import sfr_types_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_in,
    input wire logic [7:0] data_in,
    output logic open_out,
    output logic [7:0] key_out
);
    key_state_e state_r;
    key_state_e state_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
        unique case (state_r)
            KEY_IDLE: begin
                if (wr_in && data_in == `KEY_FIRST) begin
                    state_nxt = KEY_HALF;
                    cnt_nxt = `KEY_WIN_CYC;
                end
            end
            KEY_HALF: begin
                // any other value breaks the sequence
                if (wr_in && data_in == `KEY_SECOND) begin
                    state_nxt = KEY_OPEN; // [RQ16]
                    cnt_nxt = `KEY_WIN_CYC;
                end else if (wr_in || cnt_r == 3'h0) begin
                    state_nxt = KEY_IDLE;
                end
            end
            KEY_OPEN: begin
                if (cnt_r == 3'h0) begin
                    state_nxt = KEY_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= KEY_IDLE;
            cnt_r <= 3'h0;
            open_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            open_out <= (state_nxt == KEY_OPEN); // [RQ16]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_out <= `R_KEY;
        end else if (wr_in) begin
            key_out <= data_in;
        end
    end
endmodule : key_unlock
`default_nettype wire

// *** verif/special_function_register_map_tb_top.sv ***
// self-checking bench for the special-function register window
`timescale 1ns/100ps
`default_nettype none
`include "sfr_map_consts.svh"
module special_function_register_map_tb_top;
    import sfr_types_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    sfr_req_s req_in = '0;
    bit_req_s bit_in = '0;
    core_evt_s evt_in = '0;
    ser_byte_s [1:0] rx_in = '0;
    logic [7:0] rd_data_out, stack_out, psel_out;
    logic rd_valid_out, bit_data_out, bit_valid_out;
    logic [15:0] ptr_addr_out;
    logic [3:0][7:0] port_out;
    ser_byte_s [1:0] tx_out;
    logic [1:0][7:0] ser_ctl_out;
    int err_count = 0;
    int check_count = 0;
    sfr_map dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .bit_in(bit_in),
        .evt_in(evt_in), .rx_in(rx_in), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .bit_data_out(bit_data_out),
        .bit_valid_out(bit_valid_out), .ptr_addr_out(ptr_addr_out), .stack_out(stack_out),
        .port_out(port_out), .tx_out(tx_out), .ser_ctl_out(ser_ctl_out),
        .psel_out(psel_out));
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    task automatic finish_test();
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // requests are held across exactly one taking edge, released just after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ind = 1'b0);
        @(posedge clk_in);
        #1 req_in = '{rd: 1'b0, wr: 1'b1, ind: ind, addr: a, data: d};
        @(posedge clk_in);
        #1 req_in = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic ind = 1'b0,
        input logic ev = 1'b1);
        @(posedge clk_in);
        #1 req_in = '{rd: 1'b1, wr: 1'b0, ind: ind, addr: a, data: 8'h00};
        @(posedge clk_in);
        #1 req_in = '0;
        chk("read valid", {15'h0, ev}, {15'h0, rd_valid_out});
        if (ev) chk("read data", {8'h00, exp}, {8'h00, rd_data_out});
    endtask : rd
    task automatic bitop(input bit_op_e op, input logic [7:0] a, input logic old,
        input logic v = 1'b0);
        @(posedge clk_in);
        #1 bit_in = '{valid: 1'b1, op: op, addr: a, val: v};
        @(posedge clk_in);
        #1 bit_in = '0;
        chk("bit valid", 16'h1, {15'h0, bit_valid_out});
        chk("bit old", {15'h0, old}, {15'h0, bit_data_out});
    endtask : bitop
    task automatic pulse(input core_evt_s e);
        @(posedge clk_in);
        #1 evt_in = e;
        @(posedge clk_in);
        #1 evt_in = '0;
    endtask : pulse
    task automatic t_reset_and_window();
        rd(`A_STACK, `R_STACK);
        rd(`A_PSEL, `R_PSEL);
        rd(`A_PORT2, `R_PORT);
        chk("port2 latch", 16'h00ff, {8'h00, port_out[2]});
        rd(8'h8f, 8'h00);
        wr(8'h8f, 8'h5a);
        rd(8'h8f, 8'h00);
        wr(`A_PORT0, 8'h3c, 1'b1);
        rd(`A_PORT0, 8'h3c, 1'b1);
        rd(`A_PORT0, `R_PORT);
        chk("port0 latch", 16'h00ff, {8'h00, port_out[0]});
        rd(8'h7f, 8'h00, 1'b0, 1'b0);
        rd(`A_AUXOP, 8'h00);
    endtask : t_reset_and_window
    task automatic t_ports_timers();
        wr(`A_PORT0, 8'h96);
        rd(`A_PORT0, 8'h96);
        chk("port0 latch", 16'h0096, {8'h00, port_out[0]});
        bitop(BIT_WRITE, 8'h80, 1'b0, 1'b1);
        chk("port0 latch", 16'h0097, {8'h00, port_out[0]});
        wr(`A_PORT3, 8'h69);
        chk("port3 latch", 16'h0069, {8'h00, port_out[3]});
        bitop(BIT_CLEAR, 8'h93, 1'b1);
        chk("port1 latch", 16'h00f7, {8'h00, port_out[1]});
        bitop(BIT_SET, 8'h93, 1'b0);
        bitop(BIT_READ, 8'h93, 1'b1);
        chk("port1 latch", 16'h00ff, {8'h00, port_out[1]});
        wr(`A_TMR0L, 8'h11);
        wr(`A_TMR1H, 8'h22);
        wr(`A_TMR2H, 8'h33);
        rd(`A_TMR0L, 8'h11);
        rd(`A_TMR1H, 8'h22);
        rd(`A_TMR2H, 8'h33);
        rd(`A_TMR1L, 8'h00);
    endtask : t_ports_timers
    task automatic t_pointers();
        wr(`A_PTR0L, 8'hff);
        wr(`A_PTR0H, 8'h12);
        chk("active pointer", 16'h12ff, ptr_addr_out);
        wr(`A_PSEL, 8'h30);
        pulse('{push: 1'b0, pop: 1'b0, external_data_move: 1'b1, inc: 1'b0});
        chk("toggled pointer", 16'h0000, ptr_addr_out);
        chk("select reg", 16'h0035, {8'h00, psel_out});
        wr(`A_PSEL, 8'h91);
        pulse('{push: 1'b0, pop: 1'b0, external_data_move: 1'b1, inc: 1'b0});
        chk("down step", 16'hffff, ptr_addr_out);
        rd(`A_PTR1H, 8'hff);
        wr(`A_PSEL, 8'h00);
        rd(`A_PSEL, `R_PSEL);
        chk("pointer0 stepped", 16'h1300, ptr_addr_out);
        pulse('{push: 1'b0, pop: 1'b0, external_data_move: 1'b0, inc: 1'b1});
        rd(`A_PTR0L, 8'h01);
    endtask : t_pointers
    task automatic t_stack();
        wr(`A_STACK, 8'hfe);
        chk("stack written", 16'h00fe, {8'h00, stack_out});
        pulse('{push: 1'b1, pop: 1'b0, external_data_move: 1'b0, inc: 1'b0});
        pulse('{push: 1'b1, pop: 1'b1, external_data_move: 1'b0, inc: 1'b0});
        chk("stack wrap", 16'h0000, {8'h00, stack_out});
        pulse('{push: 1'b0, pop: 1'b1, external_data_move: 1'b0, inc: 1'b0});
        rd(`A_STACK, 8'hff);
    endtask : t_stack
    task automatic t_serial();
        wr(`A_SER0BUF, 8'ha5);
        chk("tx0 load", 16'h1, {15'h0, tx_out[0].load});
        chk("tx0 data", 16'h00a5, {8'h00, tx_out[0].data});
        @(posedge clk_in);
        #1 rx_in[0] = '{load: 1'b1, data: 8'h3c};
        @(posedge clk_in);
        #1 rx_in[0] = '0;
        rd(`A_SER0BUF, 8'h3c);
        wr(`A_SER0CTL, 8'h5a);
        wr(`A_SER1CTL, 8'ha3);
        chk("serial0 ctl", 16'h005a, {8'h00, ser_ctl_out[0]});
        chk("serial1 ctl", 16'h00a3, {8'h00, ser_ctl_out[1]});
        wr(`A_SER1BUF, 8'h5c);
        chk("tx1 load", 16'h1, {15'h0, tx_out[1].load});
        chk("tx1 data", 16'h005c, {8'h00, tx_out[1].data});
        rd(`A_SER1BUF, 8'h00);
    endtask : t_serial
    task automatic t_unlock();
        wr(`A_PAGECTL, 8'hff);
        rd(`A_PAGECTL, `R_PAGECTL);
        wr(`A_KEY, `KEY_FIRST);
        wr(`A_KEY, `KEY_SECOND);
        wr(`A_PAGECTL, 8'ha0);
        wr(`A_WDCTL, 8'h0b);
        rd(`A_PAGECTL, 8'hbf);
        rd(`A_WDCTL, 8'h0b);
        repeat (8) @(posedge clk_in);
        wr(`A_PAGECTL, 8'h00);
        rd(`A_PAGECTL, 8'hbf);
        wr(`A_WDCTL, 8'hf0);
        rd(`A_WDCTL, 8'hfb);
        rd(`A_KEY, `KEY_SECOND);
    endtask : t_unlock
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        #1 rst_in = 1'b0;
        t_reset_and_window();
        t_ports_timers();
        t_pointers();
        t_stack();
        t_serial();
        t_unlock();
        finish_test();
    end
endmodule : special_function_register_map_tb_top
`default_nettype wire
